// *** bench/tb_top.sv ***
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tcc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rdData, c1, c2, c3;
    logic        capLevel = 1'b0;
    logic        extRun = 1'b0;
    logic [1:0]  acts [3] = '{TCC_ACT_SET, TCC_ACT_CLEAR, TCC_ACT_TOGGLE};
    logic [2:0]  pins = 3'b101;
    wire logic   pready, pslverr, pinIn, pinOut, pinOeN, extClk, timerIrq;
    wire logic [31:0] prdata;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #5 core_clk = ~core_clk;
    tcc_timer dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .channel0PinIn(pinIn), .channel0PinOut(pinOut),
        .channel0PinOeN(pinOeN), .extTimerClockPin(extClk), .timerIrq(timerIrq));
    tcc_pad_model pads (.core_clk(core_clk), .capLevel(capLevel), .extRun(extRun),
        .pinOut(pinOut), .pinOeN(pinOeN), .channel0PinIn(pinIn), .extTimerClockPin(extClk));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdData = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : regWr
    task automatic regRd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : regRd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : chkRange
    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            stop_test;
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        regRd(TCC_CTRL_OFS);
        chk(rdData, {25'h0, TCC_CTRL_RST});
        regRd(TCC_MODLIM_OFS);
        chk(rdData, {16'h0, TCC_MODLIM_RST});
        regRd(TCC_CH0VAL_OFS);
        chk(rdData, {16'h0, TCC_VAL_RST});
        regRd(TCC_COUNT_OFS);
        chk(rdData, 32'h0);
        regRd(8'h20);
        chk(rdData, 32'h0);
        regWr(TCC_CTRL_OFS, 32'h0);
        regRd(TCC_COUNT_OFS);
        c1 = rdData;
        regRd(TCC_COUNT_OFS);
        c2 = rdData;
        regRd(TCC_COUNT_OFS);
        c3 = rdData;
        chk(c3 - c2, c2 - c1);
        chkRange(c2 - c1, 32'h1, 32'h10);
        for (int s = 0; s <= 6; s++) begin
            regWr(TCC_CTRL_OFS, 32'h60);
            regWr(TCC_CTRL_OFS, 32'(s));
            repeat (1024) @(posedge core_clk);
            regWr(TCC_CTRL_OFS, 32'h20 | 32'(s));
            repeat (8) @(posedge core_clk);
            regRd(TCC_COUNT_OFS);
            chkRange(rdData, 32'(1024 >> s), 32'((1040 >> s) + 1));
            c2 = rdData;
            regRd(TCC_COUNT_OFS);
            chk(rdData, c2);
        end
        regWr(TCC_MODLIM_OFS, 32'hF);
        regWr(TCC_STAT_OFS, 32'hF);
        regWr(TCC_CTRL_OFS, 32'h50);
        repeat (40) @(posedge core_clk);
        regRd(TCC_COUNT_OFS);
        chkRange(rdData, 32'h0, 32'hF);
        regRd(TCC_STAT_OFS);
        chk(rdData, 32'h9);
        chk({31'h0, timerIrq}, 32'h1);
        regWr(TCC_CTRL_OFS, 32'h30);
        regWr(TCC_STAT_OFS, 32'h1);
        regRd(TCC_STAT_OFS);
        chk(rdData, 32'h0);
        regWr(TCC_MODLIM_OFS, 32'hFFFF);
        regWr(TCC_CH1CTL_OFS, 32'h41);
        regWr(TCC_CH1VAL_OFS, 32'h1E);
        regWr(TCC_CH0VAL_OFS, 32'h14);
        for (int i = 0; i < 3; i++) begin
            regWr(TCC_CTRL_OFS, 32'h60);
            regWr(TCC_CH0CTL_OFS, 32'h41 | {27'h0, acts[i], 3'h0});
            regWr(TCC_CTRL_OFS, 32'h0);
            repeat (100) @(posedge core_clk);
            regWr(TCC_CTRL_OFS, 32'h20);
            chk({31'h0, pinOut}, {31'h0, pins[i]});
            chk({31'h0, pinOeN}, 32'h0);
            chk({31'h0, timerIrq}, 32'h1);
            regRd(TCC_STAT_OFS);
            chk(rdData, 32'h6);
            regWr(TCC_STAT_OFS, 32'h7);
        end
        regWr(TCC_CH0VAL_OFS, 32'h90);
        regWr(TCC_CH0VAL_OFS, 32'h28);
        regWr(TCC_CTRL_OFS, 32'h0);
        repeat (50) @(posedge core_clk);
        regWr(TCC_CTRL_OFS, 32'h20);
        regRd(TCC_STAT_OFS);
        chk(rdData, 32'h0);
        chk({31'h0, pinOut}, 32'h1);
        regRd(TCC_COUNT_OFS);
        c1 = rdData;
        for (int i = 1; i <= 3; i++) begin
            regWr(TCC_CH0CTL_OFS, 32'h40 | 32'(i << 1));
            repeat (10) @(posedge core_clk);
            regWr(TCC_STAT_OFS, 32'h7);
            for (int e = 0; e < 2; e++) begin
                capLevel <= ~capLevel;
                repeat (10) @(posedge core_clk);
                c2 = {31'h0, (e == 0) ? (i != 2) : (i != 1)};
                chk({31'h0, timerIrq}, c2);
                regRd(TCC_STAT_OFS);
                chk({31'h0, rdData[TCC_CH0F_B]}, c2);
                regWr(TCC_STAT_OFS, 32'h7);
            end
        end
        regRd(TCC_CH0VAL_OFS);
        chk(rdData, c1);
        regWr(TCC_CTRL_OFS, 32'h60);
        regWr(TCC_CTRL_OFS, 32'h8);
        extRun <= 1'b1;
        repeat (160) @(posedge core_clk);
        extRun <= 1'b0;
        repeat (10) @(posedge core_clk);
        regRd(TCC_COUNT_OFS);
        chk(rdData, 32'h28);
        regWr(TCC_CTRL_OFS, 32'h60);
        regWr(TCC_MODLIM_OFS, 32'hF);
        regWr(TCC_STAT_OFS, 32'h7);
        regWr(TCC_CH0CTL_OFS, 32'h21);
        regWr(TCC_CTRL_OFS, 32'h10);
        repeat (20) @(posedge core_clk);
        regWr(TCC_CTRL_OFS, 32'h30);
        chk({31'h0, pinOut}, 32'h0);
        chk({31'h0, pinOeN}, 32'h0);
        regRd(TCC_COUNT_OFS);
        chk(rdData, 32'h8);
        regRd(TCC_STAT_OFS);
        chk(rdData, 32'h1);
        stop_test;
    end
endmodule : tb_top
`default_nettype wire

// *** bench/tcc_pad_model.sv ***
// Pad-side model: event source on the channel pin and external timer clock
`timescale 1ns/1ps
`default_nettype none
module tcc_pad_model (
    // Clock
    input  wire logic core_clk,
    // Bench control
    input  wire logic capLevel,
    input  wire logic extRun,
    // Pads
    input  wire logic pinOut,
    input  wire logic pinOeN,
    output logic      channel0PinIn,
    output logic      extTimerClockPin
);
    logic [1:0] div_q = 2'h0;
    assign channel0PinIn = pinOeN ? capLevel : pinOut;
    always_ff @(posedge core_clk) begin
        div_q <= extRun ? div_q + 2'h1 : 2'h0;
    end
    assign extTimerClockPin = div_q[1];
endmodule : tcc_pad_model
`default_nettype wire

// *** bench/tcc_timer_chk.sv ***
// Checker for bus answers, pin drive and interrupt quieting of the timer
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_chk
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pin and interrupt
    input wire logic        channel0PinOeN,
    input wire logic        timerIrq
);
    logic        wr;
    logic [4:0]  shadow_q;
    logic [3:0]  hold_q;
    logic [2:0]  quiet_q;
    logic        cntRd_q;
    logic        prevOk_q;
    logic [15:0] prevCnt_q;
    logic        ctrlWr;
    assign wr = psel && penable && !pready && pwrite;
    assign ctrlWr = wr && paddr == TCC_CTRL_OFS;
    // Shadow of halt, ch0 mode, ch0/ch1/overflow enables
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shadow_q <= 5'h01;
        end else begin
            if (ctrlWr) shadow_q[0] <= pwdata[TCC_HALT_B];
            if (wr && paddr == TCC_CH0CTL_OFS) shadow_q[1] <= pwdata[TCC_CHMODE_B];
            if (wr && paddr == TCC_CH0CTL_OFS) shadow_q[2] <= pwdata[TCC_CHIE_B];
            if (wr && paddr == TCC_CH1CTL_OFS) shadow_q[3] <= pwdata[TCC_CHIE_B];
            if (wr && paddr == TCC_STAT_OFS) shadow_q[4] <= pwdata[TCC_OVIE_B];
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= 4'h0;
            quiet_q <= 3'h0;
            cntRd_q <= 1'b0;
            prevOk_q <= 1'b0;
            prevCnt_q <= 16'h0000;
        end else begin
            hold_q <= (ctrlWr || !shadow_q[0]) ? 4'h0 : hold_q + {3'h0, hold_q != 4'hF};
            quiet_q <= (|shadow_q[4:2]) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            if (psel && penable && !pready) cntRd_q <= !pwrite && paddr == TCC_COUNT_OFS;
            if (ctrlWr) prevOk_q <= 1'b0;
            else if (pready && cntRd_q) prevOk_q <= hold_q >= 4'h8;
            if (pready && cntRd_q) prevCnt_q <= prdata[15:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer; psel && penable && !pready |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("ready not single after access");
    property p_ready_cause; pready |-> $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
    property p_no_err; !pslverr; endproperty
    a_no_err: assert property (p_no_err) else $error("slave error raised");
    property p_cnt_width; pready && cntRd_q |-> prdata[31:16] == 16'h0000; endproperty
    a_cnt_width: assert property (p_cnt_width) else $error("count above 16 bits");
    property p_cnt_frozen;
        pready && cntRd_q && prevOk_q && hold_q >= 4'h8 |-> prdata[15:0] == prevCnt_q;
    endproperty
    a_cnt_frozen: assert property (p_cnt_frozen) else $error("halted count moved");
    property p_oe_drive; $rose(shadow_q[1]) |-> ##[1:3] !channel0PinOeN; endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("compare pin not driven");
    property p_oe_release; $fell(shadow_q[1]) |-> ##[1:3] channel0PinOeN; endproperty
    a_oe_release: assert property (p_oe_release) else $error("capture pin driven");
    property p_irq_quiet; quiet_q >= 3'h3 |-> !timerIrq; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with all enables off");
endmodule : tcc_timer_chk
bind tcc_timer tcc_timer_chk #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .channel0PinOeN(channel0PinOeN), .timerIrq(timerIrq));
`default_nettype wire

// *** design/tcc_pkg.sv ***
// Package with register map, field positions and timing for the capture/compare timer
package tcc_pkg;
    // Register byte offsets
    localparam logic [7:0] TCC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] TCC_COUNT_OFS   = 8'h04;
    localparam logic [7:0] TCC_MODLIM_OFS  = 8'h08;
    localparam logic [7:0] TCC_CH0CTL_OFS  = 8'h0C;
    localparam logic [7:0] TCC_CH0VAL_OFS  = 8'h10;
    localparam logic [7:0] TCC_CH1CTL_OFS  = 8'h14;
    localparam logic [7:0] TCC_CH1VAL_OFS  = 8'h18;
    localparam logic [7:0] TCC_STAT_OFS    = 8'h1C;
    // Control register fields
    localparam int TCC_PS_LSB    = 0;
    localparam int TCC_PS_W      = 3;
    localparam int TCC_EXTCLK_B  = 3;
    localparam int TCC_MODEN_B   = 4;
    localparam int TCC_HALT_B    = 5;
    localparam int TCC_CLEAR_B   = 6;
    // Channel control fields
    localparam int TCC_CHMODE_B  = 0;
    localparam int TCC_EDGE_LSB  = 1;
    localparam int TCC_ACT_LSB   = 3;
    localparam int TCC_TOV_B     = 5;
    localparam int TCC_CHIE_B    = 6;
    // Status fields (flags write one to clear; bit 3 is the overflow interrupt enable, written plainly)
    localparam int TCC_OVF_B     = 0;
    localparam int TCC_CH0F_B    = 1;
    localparam int TCC_CH1F_B    = 2;
    localparam int TCC_OVIE_B    = 3;
    // Edge select codes
    localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
    localparam logic [1:0] TCC_EDGE_FALL = 2'h2;
    localparam logic [1:0] TCC_EDGE_ANY  = 2'h3;
    // Compare action codes
    localparam logic [1:0] TCC_ACT_NONE   = 2'h0;
    localparam logic [1:0] TCC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] TCC_ACT_SET    = 2'h3;
    // Reset values
    localparam logic [15:0] TCC_MODLIM_RST = 16'hFFFF;
    localparam logic [15:0] TCC_VAL_RST    = 16'hFFFF;
    localparam logic [6:0]  TCC_CTRL_RST   = 7'h20;
    // Prescale rates are 2**select for selects 0..6; select 7 is unused
    localparam logic [2:0]  TCC_PS_MAX     = 3'h6;
endpackage : tcc_pkg

// *** design/tcc_timer.sv ***
// Two-channel capture/compare timer with APB register access
//
// Summary of operation
// RULE1: Sixteen-bit up-counter, free-running or modulo, is the reference for channels.
// RULE2: Modulo limit comes from software-written high and low limit bytes; code takes the whole limit in one register write.
// RULE3: Counter readable any time without disturbing the count.
// RULE4: Three-bit prescale select picks seven bus-clock rates; separate bit picks external clock.
// RULE5: External clock must run at most half the bus clock; edges are only counted up to a quarter of the bus clock.
// RULE6: Active capture edge copies counter into channel value register.
// RULE7: Capture edge selectable as rising, falling or either.
// RULE8: Each capture can raise the timer interrupt request.
// RULE9: Channel 0 compare match sets, clears or toggles its pin.
// RULE10: Compare match on either channel can raise an interrupt request.
// RULE11: Channel 0 capture or compare; channel 1 compare only, no pin.
// RULE12: Software must never put channel 1 into capture mode.
// RULE13: Per-channel option inverts channel pin on each overflow; code skips it when a channel 0 compare match falls on the same tick.
// RULE14: Controls to halt and to clear the counter.
// RULE15: Compare value write takes effect at once; passed values miss.
// RULE16: Smaller compare values should be written in the compare interrupt.
// RULE17: Larger compare values should be written in the overflow interrupt.
// RULE18: Overflow condition asserted at end of each overflow period.
// RULE19: Compare condition asserted at the match ending the pulse.
// RULE20: Channel 0 pin and external clock share pads with port pins.
// RULE21: Modulo mode wraps to zero after reaching limit and flags overflow.
// RULE22: Capture and external clock pins synchronised before edge detection.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Shared pads: channel 0 on port_b_bit2, external clock on port_b_bit3
    input  wire logic              channel0PinIn,
    output logic                   channel0PinOut,
    output logic                   channel0PinOeN,
    input  wire logic              extTimerClockPin,
    // Interrupt request
    output logic                   timerIrq
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] modLimit_q;
    logic [6:0]       ctrl_q;
    logic [6:0]       chCtl_q [2];
    logic [CNT_W-1:0] chVal_q [2];
    logic [3:0]       stat_q;
    logic [5:0]       preDiv_q;
    logic [2:0]       pinSync_q;
    logic [2:0]       clkSync_q;
    logic             pinLvl_q;
    logic             clkLvl_q;
    logic             pinState_q;

    logic             wrEn;
    logic             rdEn;
    logic             tick;
    logic             atLimit;
    logic             ovf;
    logic             pinRise;
    logic             pinFall;
    logic             capEvt;
    logic [1:0]       cmpEvt;
    logic [2:0]       psSel;
    logic [5:0]       psMask;

    assign wrEn  = psel & penable & pwrite;
    assign rdEn  = psel & penable & ~pwrite;
    assign psSel = ctrl_q[TCC_PS_LSB +: TCC_PS_W];

    // RULE22: three-stage pin synchronisers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinSync_q <= 3'h0;
            clkSync_q <= 3'h0;
        end else begin
            pinSync_q <= {pinSync_q[1:0], channel0PinIn};
            clkSync_q <= {clkSync_q[1:0], extTimerClockPin};
        end
    end

    // RULE22: level accepted once stages two and three agree
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinLvl_q <= 1'b0;
            clkLvl_q <= 1'b0;
        end else begin
            if (pinSync_q[1] == pinSync_q[2]) begin
                pinLvl_q <= pinSync_q[2];
            end
            if (clkSync_q[1] == clkSync_q[2]) begin
                clkLvl_q <= clkSync_q[2];
            end
        end
    end

    assign pinRise = (pinSync_q[1] == pinSync_q[2]) & pinSync_q[2] & ~pinLvl_q;
    assign pinFall = (pinSync_q[1] == pinSync_q[2]) & ~pinSync_q[2] & pinLvl_q;

    // RULE4: prescaler divider, rate 2**select
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            preDiv_q <= 6'h00;
        end else if (ctrl_q[TCC_HALT_B] || ctrl_q[TCC_CLEAR_B]) begin
            preDiv_q <= 6'h00;
        end else begin
            preDiv_q <= preDiv_q + 6'h01;
        end
    end

    always_comb begin
        psMask = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < int'(psSel)) begin
                psMask[i] = 1'b1;
            end
        end
    end

    // RULE4: tick from external clock rise or divided bus clock
    always_comb begin
        if (ctrl_q[TCC_EXTCLK_B]) begin
            // RULE5: one tick per external rise, valid up to a quarter of bus rate (each level held two bus clocks)
            tick = (clkSync_q[1] == clkSync_q[2]) & clkSync_q[2] & ~clkLvl_q;
        end else begin
            tick = ((preDiv_q & psMask) == psMask) && (psSel <= TCC_PS_MAX);
        end
        tick = tick & ~ctrl_q[TCC_HALT_B] & ~ctrl_q[TCC_CLEAR_B];
    end

    // RULE21: limit is modulo value, or all ones when free-running
    assign atLimit = ctrl_q[TCC_MODEN_B] ? (count_q == modLimit_q) : (&count_q);
    assign ovf     = tick & atLimit;

    // RULE1: counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
        // RULE14: clear control
        end else if (ctrl_q[TCC_CLEAR_B]) begin
            count_q <= '0;
        // RULE21: wrap to zero at limit
        end else if (ovf) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    // RULE7: rise, fall or either edge
    assign capEvt = ~chCtl_q[0][TCC_CHMODE_B]
                  & ((pinRise & chCtl_q[0][TCC_EDGE_LSB])
                  |  (pinFall & chCtl_q[0][TCC_EDGE_LSB+1]));

    // RULE15: compare against live value so a passed value is missed
    generate
        for (genvar c = 0; c < 2; c++) begin : g_cmp
            assign cmpEvt[c] = (c == 1 || chCtl_q[c][TCC_CHMODE_B])
                             & tick & (count_q == chVal_q[c]);
        end
    endgenerate

    // Control and modulo registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q     <= TCC_CTRL_RST;
            modLimit_q <= TCC_MODLIM_RST;
        end else if (wrEn && paddr == TCC_CTRL_OFS) begin
            ctrl_q <= pwdata[6:0];
        end else begin
            // Clear is a one-cycle action
            ctrl_q[TCC_CLEAR_B] <= 1'b0;
            // RULE2: whole limit from one register write, no separate bytes
            if (wrEn && paddr == TCC_MODLIM_OFS) begin
                modLimit_q <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Channel registers
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    chCtl_q[c] <= 7'h00;
                    chVal_q[c] <= TCC_VAL_RST;
                end else begin
                    if (wrEn && paddr == (c == 0 ? TCC_CH0CTL_OFS : TCC_CH1CTL_OFS)) begin
                        // RULE11: channel 1 mode bit forced to compare
                        chCtl_q[c] <= (c == 1) ? (pwdata[6:0] | 7'h01) : pwdata[6:0];
                    end
                    // RULE6: capture wins over a software write
                    if (c == 0 && capEvt) begin
                        chVal_q[c] <= count_q;
                    // RULE15: write replaces compare value at once
                    end else if (wrEn && paddr == (c == 0 ? TCC_CH0VAL_OFS : TCC_CH1VAL_OFS)) begin
                        chVal_q[c] <= pwdata[CNT_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // Status flags: hardware set wins over write-one clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= 4'h0;
        end else begin
            if (wrEn && paddr == TCC_STAT_OFS) begin
                stat_q[2:0]        <= stat_q[2:0] & ~pwdata[2:0];
                stat_q[TCC_OVIE_B] <= pwdata[TCC_OVIE_B];
            end
            // RULE18: overflow flag at end of period
            if (ovf) begin
                stat_q[TCC_OVF_B] <= 1'b1;
            end
            // RULE8: capture flag
            // RULE19: compare flag at the match ending the pulse
            if (capEvt || cmpEvt[0]) begin
                stat_q[TCC_CH0F_B] <= 1'b1;
            end
            // RULE10: channel 1 compare flag, which raises the interrupt when its enable is set
            if (cmpEvt[1]) begin
                stat_q[TCC_CH1F_B] <= 1'b1;
            end
        end
    end

    // RULE9: channel 0 pin action, compare then overflow toggle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinState_q <= 1'b0;
        end else if (chCtl_q[0][TCC_CHMODE_B]) begin
            if (cmpEvt[0]) begin
                case (chCtl_q[0][TCC_ACT_LSB +: 2])
                    TCC_ACT_TOGGLE: pinState_q <= ~pinState_q;
                    TCC_ACT_CLEAR:  pinState_q <= 1'b0;
                    TCC_ACT_SET:    pinState_q <= 1'b1;
                    default:        pinState_q <= pinState_q;
                endcase
            // RULE13: invert pin on overflow
            end else if (ovf && chCtl_q[0][TCC_TOV_B]) begin
                pinState_q <= ~pinState_q;
            end
        end
    end

    // RULE20: pad driven only in compare mode with a compare action or overflow toggle set
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            channel0PinOut <= 1'b0;
            channel0PinOeN <= 1'b1;
            timerIrq       <= 1'b0;
        end else begin
            channel0PinOut <= pinState_q;
            channel0PinOeN <= ~(chCtl_q[0][TCC_CHMODE_B]
                           & ((chCtl_q[0][TCC_ACT_LSB +: 2] != TCC_ACT_NONE)
                           |  chCtl_q[0][TCC_TOV_B]));
            timerIrq <= (stat_q[TCC_OVF_B] & stat_q[TCC_OVIE_B])
                      | (stat_q[TCC_CH0F_B] & chCtl_q[0][TCC_CHIE_B])
                      | (stat_q[TCC_CH1F_B] & chCtl_q[1][TCC_CHIE_B]);
        end
    end

    // APB: one wait state, read data registered
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (rdEn && !pready) begin
                case (paddr)
                    TCC_CTRL_OFS:   prdata <= {25'h0, ctrl_q};
                    // RULE3: plain read of live count
                    TCC_COUNT_OFS:  prdata <= {16'h0, count_q};
                    TCC_MODLIM_OFS: prdata <= {16'h0, modLimit_q};
                    TCC_CH0CTL_OFS: prdata <= {25'h0, chCtl_q[0]};
                    TCC_CH0VAL_OFS: prdata <= {16'h0, chVal_q[0]};
                    TCC_CH1CTL_OFS: prdata <= {25'h0, chCtl_q[1]};
                    TCC_CH1VAL_OFS: prdata <= {16'h0, chVal_q[1]};
                    TCC_STAT_OFS:   prdata <= {28'h0, stat_q};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : tcc_timer

`default_nettype wire
